// File: core/ifs_defines.svh
// Constants for the instruction fetch sequencer
`ifndef IFS_DEFINES_SVH
`define IFS_DEFINES_SVH
`define IFS_P_W        15
`define IFS_GRP_W      3
`define IFS_P_RST      15'h0000
`define IFS_IRQ_ENTRY  15'h0007
`define IFS_WORD_W     48
`define IFS_HALF_W     24
`define IFS_F_MSB      47
`define IFS_F_LSB      42
`define IFS_J_MSB      41
`define IFS_J_LSB      39
`define IFS_F_ILL_LO   6'h00
`define IFS_F_ILL_HI   6'h3F
`define IFS_F_SELSTOP  6'h3E
`define IFS_SEQ_W      7
`define IFS_SEQ_ZA     7'h01
`define IFS_SEQ_RO     7'h02
`define IFS_SEQ_WO     7'h04
`define IFS_SEQ_ST     7'h08
`define IFS_SEQ_IT     7'h10
`define IFS_SEQ_EXF    7'h20
`define IFS_SEQ_NJ     7'h40
`define IFS_ADDR_W     8
`define IFS_A_CTRL     8'h00
`define IFS_A_BKPT     8'h04
`define IFS_A_PLOAD    8'h08
`define IFS_A_FCODE    8'h0C
`define IFS_A_STATUS   8'h10
`define IFS_A_UHI      8'h14
`define IFS_A_ULO      8'h18
`define IFS_A_SEQ      8'h1C
`define IFS_CTRL_START 0
`define IFS_CTRL_STEP  1
`define IFS_CTRL_MCLR  2
`define IFS_CTRL_SELSW 3
`define IFS_BKPT_EN    15
`define IFS_T1         0
`define IFS_T2         1
`define IFS_T3         2
`define IFS_T4         3
`define IFS_CHAIN_W    4
`define IFS_CHAIN_GO   4'h1
`endif

// File: core/ifs_pkg.sv
// Types for the instruction fetch sequencer
`include "ifs_defines.svh"
package ifs_pkg;
   typedef enum logic [9:0] {
      S_IDLE  = 10'h001,
      S_SYNC  = 10'h002,
      S_ADV   = 10'h004,
      S_REQ   = 10'h008,
      S_WAIT  = 10'h010,
      S_LOAD  = 10'h020,
      S_CHECK = 10'h040,
      S_DISP  = 10'h080,
      S_EXEC  = 10'h100,
      S_STOP  = 10'h200
   } ifs_state_e_t;

   typedef struct packed {
      logic                  req;
      logic [`IFS_P_W-1:0]   addr;
   } ifs_mem_req_t;

   typedef struct packed {
      ifs_state_e_t             st;
      logic [`IFS_P_W-1:0]      p1;
      logic [`IFS_P_W-1:0]      p2;
      logic                     phase;
      logic [`IFS_WORD_W-1:0]   u;
      logic [`IFS_WORD_W-1:0]   hold;
      logic                     exitSel;
      logic                     stop1;
      logic                     stop2;
      logic                     fault;
      logic                     initStart;
      logic                     skipStop;
      logic                     halfMode;
      logic                     waitStor;
      logic                     initStor;
      logic                     clrFlag;
      logic [1:0]               busy;
      logic [`IFS_CHAIN_W-1:0]  chain;
      logic [2:0]               irqSync;
      logic                     irqLvl;
      logic                     irqPend;
      logic [`IFS_P_W-1:0]      bpVal;
      logic                     bpEn;
      logic                     selSw;
      ifs_mem_req_t             mem;
      logic                     seqStart;
      logic [`IFS_SEQ_W-1:0]    seqSel;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
   } ifs_regs_t;
endpackage

// File: core/ifs_fetch_sequencer.sv
// Program counter and instruction fetch sequencer with APB control
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ifs_defines.svh"
module ifs_fetch_sequencer (
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`IFS_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   output ifs_pkg::ifs_mem_req_t        memOut,
   input  wire logic                    memResume,
   input  wire logic [`IFS_WORD_W-1:0]  memData,
   output logic                         seqStart,
   output logic      [`IFS_SEQ_W-1:0]   seqSel,
   output logic      [`IFS_HALF_W-1:0]  instrUpper,
   output logic      [`IFS_P_W-1:0]     progAddr,
   output logic                         stopFlag,
   input  wire logic                    exitReq,
   input  wire logic                    exitJump,
   input  wire logic [`IFS_P_W-1:0]     jumpAddr,
   input  wire logic                    irqReq
);
   ifs_pkg::ifs_regs_t q_q;
   ifs_pkg::ifs_regs_t q_d;

   // Grouped carry increment; each bit toggles when the lower group bits
   // and all lower groups are ones
   function automatic logic [`IFS_P_W-1:0] incP(
      input logic [`IFS_P_W-1:0] p);
      logic [`IFS_P_W-1:0] tog;
      logic                grpEn;
      logic                inGrp;
      tog = '0;
      grpEn = 1'b1;
      inGrp = 1'b1;
      for (int i = 0; i < `IFS_P_W; i++) begin
         if (i % `IFS_GRP_W == 0) begin
            inGrp = 1'b1;
         end
         tog[i] = grpEn & inGrp;
         inGrp = inGrp & p[i];
         if (i % `IFS_GRP_W == `IFS_GRP_W - 1) begin
            grpEn = grpEn & inGrp;
         end
      end
      return p ^ tog;
   endfunction

   // Function code to sequence; codes are plain 6-bit hex values
   function automatic logic [`IFS_SEQ_W-1:0] decodeSeq(
      input logic [5:0] f,
      input logic [2:0] j);
      logic [`IFS_SEQ_W-1:0] s;
      s = `IFS_SEQ_RO;
      if (f >= 6'h32 && f <= 6'h37) begin
         s = `IFS_SEQ_ST;
      end else if (f >= 6'h14 && f <= 6'h1B) begin
         s = `IFS_SEQ_IT;
      end else if (f == 6'h3C) begin
         s = `IFS_SEQ_EXF;
      end else if (f == 6'h12 || f == 6'h13 || f == 6'h3D
                   || f == 6'h3E) begin
         s = j[2] ? `IFS_SEQ_WO : `IFS_SEQ_NJ;
      end else if ((f >= 6'h01 && f <= 6'h09) || f == 6'h1C
                   || f == 6'h1D || f == 6'h28 || f == 6'h29
                   || f == 6'h2C || f == 6'h2D) begin
         s = `IFS_SEQ_ZA;
      end else if (f == 6'h10 || f == 6'h11 || f == 6'h27
                   || (f >= 6'h2E && f <= 6'h31)) begin
         s = `IFS_SEQ_WO;
      end
      return s;
   endfunction

   function automatic ifs_pkg::ifs_regs_t clearVal();
      ifs_pkg::ifs_regs_t r;
      r = '0;
      r.st = ifs_pkg::S_IDLE;
      r.p1 = `IFS_P_RST;
      r.p2 = `IFS_P_RST;
      r.initStart = 1'b1;
      return r;
   endfunction

   logic [5:0]            fCode;
   logic                  illegal;
   logic                  bpHit;
   logic                  access;
   logic                  commit;
   logic                  mapped;
   logic                  wrCtrl;
   logic [31:0]           rdMux;

   assign fCode   = q_q.u[`IFS_F_MSB:`IFS_F_LSB];
   assign illegal = (fCode == `IFS_F_ILL_LO) || (fCode == `IFS_F_ILL_HI);
   assign bpHit   = q_q.bpEn && (q_q.p2 == q_q.bpVal);
   assign access  = psel && penable && !q_q.pready;
   assign commit  = psel && penable && q_q.pready;
   assign wrCtrl  = commit && pwrite && paddr == `IFS_A_CTRL;

   always_comb begin
      mapped = 1'b1;
      rdMux = '0;
      case (paddr)
         `IFS_A_CTRL:   rdMux = {28'h0000000, q_q.selSw, 3'h0};
         `IFS_A_BKPT:   rdMux = {16'h0000, q_q.bpEn, q_q.bpVal};
         `IFS_A_PLOAD:  rdMux = {17'h00000, q_q.p1};
         `IFS_A_FCODE:  rdMux = {26'h0000000, fCode};
         `IFS_A_STATUS: rdMux = {q_q.st, q_q.initStart, q_q.fault,
                                 q_q.stop2, q_q.stop1, q_q.exitSel,
                                 q_q.irqPend, 1'b0, q_q.p2};
         `IFS_A_UHI:    rdMux = {8'h00, q_q.u[`IFS_WORD_W-1:`IFS_HALF_W]};
         `IFS_A_ULO:    rdMux = {8'h00, q_q.u[`IFS_HALF_W-1:0]};
         `IFS_A_SEQ:    rdMux = {25'h0000000, q_q.seqSel};
         default:       mapped = 1'b0;
      endcase
   end

   always_comb begin
      q_d = q_q;
      q_d.mem.req = 1'b0;
      q_d.seqStart = 1'b0;
      q_d.phase = !q_q.phase;
      if (q_q.phase) begin
         q_d.p2 = q_q.p1;
      end
      // Three-stage sampler on the interrupt pin; first stage read once
      q_d.irqSync = {q_q.irqSync[1:0], irqReq};
      if (q_q.irqSync[1] == q_q.irqSync[2]) begin
         q_d.irqLvl = q_q.irqSync[2];
         if (q_q.irqSync[2] && !q_q.irqLvl) begin
            q_d.irqPend = 1'b1;
         end
      end
      // APB slave: one wait state, writes land on the completing edge
      q_d.pready = access;
      q_d.pslverr = access && !mapped;
      if (access) begin
         q_d.prdata = rdMux;
      end
      if (commit && pwrite && mapped) begin
         case (paddr)
            `IFS_A_CTRL: q_d.selSw = pwdata[`IFS_CTRL_SELSW];
            `IFS_A_BKPT: begin
               q_d.bpVal = pwdata[`IFS_P_W-1:0];
               q_d.bpEn = pwdata[`IFS_BKPT_EN];
            end
            `IFS_A_PLOAD: begin
               // Manual entry only while halted so fetch never sees a torn P
               if (q_q.st == ifs_pkg::S_IDLE
                   || q_q.st == ifs_pkg::S_STOP) begin
                  q_d.p1 = pwdata[`IFS_P_W-1:0];
               end
            end
            `IFS_A_FCODE: begin
               if (q_q.st == ifs_pkg::S_STOP) begin
                  q_d.u[`IFS_F_MSB:`IFS_F_LSB] = pwdata[5:0];
                  if (pwdata[5:0] != `IFS_F_ILL_LO
                      && pwdata[5:0] != `IFS_F_ILL_HI) begin
                     q_d.fault = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end
      case (q_q.st)
         ifs_pkg::S_IDLE: begin
            if (wrCtrl && q_q.initStart && (pwdata[`IFS_CTRL_START]
                || pwdata[`IFS_CTRL_STEP])) begin
               q_d.initStart = 1'b0;
               q_d.stop1 = pwdata[`IFS_CTRL_STEP];
               q_d.st = ifs_pkg::S_SYNC;
            end
         end
         ifs_pkg::S_SYNC: begin
            if (q_q.p1 == q_q.p2) begin
               q_d.st = ifs_pkg::S_REQ;
            end
         end
         ifs_pkg::S_ADV: begin
            // Even phase only: the odd phase reloads the second rank
            if (!q_q.phase) begin
               q_d.p1 = incP(q_q.p2);
               q_d.st = ifs_pkg::S_SYNC;
            end
         end
         ifs_pkg::S_REQ: begin
            if (!q_q.busy[q_q.p2[0]]) begin
               q_d.mem.req = 1'b1;
               q_d.mem.addr = q_q.p2;
               q_d.initStor = 1'b1;
               q_d.waitStor = 1'b1;
               q_d.busy[q_q.p2[0]] = 1'b1;
               q_d.st = ifs_pkg::S_WAIT;
            end
         end
         ifs_pkg::S_WAIT: begin
            if (memResume && q_q.waitStor) begin
               q_d.hold = memData;
               q_d.waitStor = 1'b0;
               q_d.initStor = 1'b0;
               q_d.busy[q_q.mem.addr[0]] = 1'b0;
               q_d.halfMode = 1'b0;
               q_d.chain = `IFS_CHAIN_GO;
               q_d.st = ifs_pkg::S_LOAD;
            end
         end
         ifs_pkg::S_LOAD: begin
            q_d.chain = {q_q.chain[`IFS_CHAIN_W-2:0], 1'b0};
            if (q_q.chain[`IFS_T1]) begin
               q_d.exitSel = !q_q.halfMode;
               q_d.clrFlag = 1'b1;
            end
            if (q_q.chain[`IFS_T2] && q_q.clrFlag) begin
               q_d.u[`IFS_WORD_W-1:`IFS_HALF_W] = '0;
               if (!q_q.halfMode) begin
                  q_d.u[`IFS_HALF_W-1:0] = '0;
               end
            end
            if (q_q.chain[`IFS_T3]) begin
               q_d.clrFlag = 1'b0;
               if (q_q.halfMode) begin
                  q_d.u[`IFS_WORD_W-1:`IFS_HALF_W] =
                     q_q.u[`IFS_HALF_W-1:0];
               end else begin
                  q_d.u = q_q.hold;
               end
            end
            if (q_q.chain[`IFS_T4]) begin
               q_d.st = ifs_pkg::S_CHECK;
            end
         end
         ifs_pkg::S_CHECK: begin
            // A step, breakpoint or illegal code withholds the final fetch step
            if (q_q.stop1 || bpHit || illegal) begin
               q_d.stop2 = 1'b1;
               q_d.stop1 = 1'b0;
               q_d.fault = illegal;
               q_d.st = ifs_pkg::S_STOP;
            end else begin
               q_d.st = ifs_pkg::S_DISP;
            end
         end
         ifs_pkg::S_DISP: begin
            q_d.seqSel = decodeSeq(fCode,
                                   q_q.u[`IFS_J_MSB:`IFS_J_LSB]);
            if (q_d.seqSel == `IFS_SEQ_NJ && fCode == `IFS_F_SELSTOP
                && q_q.selSw && !q_q.skipStop) begin
               q_d.stop2 = 1'b1;
               q_d.st = ifs_pkg::S_STOP;
            end else begin
               q_d.seqStart = 1'b1;
               q_d.skipStop = 1'b0;
               q_d.st = ifs_pkg::S_EXEC;
            end
         end
         ifs_pkg::S_EXEC: begin
            // The selected sequence may still be finishing after its exit
            if (exitReq) begin
               if (exitJump) begin
                  q_d.p1 = jumpAddr;
                  q_d.st = ifs_pkg::S_SYNC;
               end else if (q_q.irqPend) begin
                  q_d.p1 = `IFS_IRQ_ENTRY;
                  q_d.irqPend = &q_q.irqSync[2:1] && !q_q.irqLvl;
                  q_d.st = ifs_pkg::S_SYNC;
               end else if (q_q.exitSel) begin
                  q_d.halfMode = 1'b1;
                  q_d.chain = `IFS_CHAIN_GO;
                  q_d.st = ifs_pkg::S_LOAD;
               end else begin
                  q_d.st = ifs_pkg::S_ADV;
               end
            end
         end
         ifs_pkg::S_STOP: begin
            // Restart skips the checks so a breakpoint word runs once
            if (wrCtrl && !q_q.fault && (pwdata[`IFS_CTRL_START]
                || pwdata[`IFS_CTRL_STEP])) begin
               q_d.stop2 = 1'b0;
               q_d.skipStop = 1'b1;
               q_d.stop1 = pwdata[`IFS_CTRL_STEP];
               q_d.st = ifs_pkg::S_DISP;
            end
         end
         default: q_d.st = ifs_pkg::S_IDLE;
      endcase
      // Step while running arms the first stop flag; set beats clear
      if (wrCtrl && pwdata[`IFS_CTRL_STEP]
          && q_q.st != ifs_pkg::S_IDLE && q_q.st != ifs_pkg::S_STOP) begin
         q_d.stop1 = 1'b1;
      end
      if (wrCtrl && pwdata[`IFS_CTRL_MCLR]) begin
         q_d = clearVal();
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         q_q <= clearVal();
      end else begin
         q_q <= q_d;
      end
   end
   assign prdata     = q_q.prdata;
   assign pready     = q_q.pready;
   assign pslverr    = q_q.pslverr;
   assign memOut     = q_q.mem;
   assign seqStart   = q_q.seqStart;
   assign seqSel     = q_q.seqSel;
   assign instrUpper = q_q.u[`IFS_WORD_W-1:`IFS_HALF_W];
   assign progAddr   = q_q.p2;
   assign stopFlag   = q_q.stop2;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   AST_P_INC: assert property (
      (q_q.st == ifs_pkg::S_ADV && !q_q.phase) |=>
      q_q.p1 == `IFS_P_W'($past(q_q.p2) + `IFS_P_W'(1)))
      else $error("P did not advance by one");
   AST_ADV_SRC: assert property (
      (q_q.st == ifs_pkg::S_ADV && $past(q_q.st) != ifs_pkg::S_ADV) |->
      ($past(q_q.st) == ifs_pkg::S_EXEC && !$past(q_q.exitSel)))
      else $error("P advance without full exit");
   AST_GRP_CARRY: assert property (
      (q_q.st == ifs_pkg::S_ADV && !q_q.phase
       && q_q.p2[`IFS_GRP_W-1:0] != 3'h7) |=>
      q_q.p1[`IFS_P_W-1:`IFS_GRP_W] == $past(q_q.p2[`IFS_P_W-1:`IFS_GRP_W]))
      else $error("Upper groups changed without carry");
   AST_IRQ_ENTRY: assert property (
      (q_q.st == ifs_pkg::S_EXEC && exitReq && !exitJump && q_q.irqPend
       && !wrCtrl) |=> q_q.p1 == `IFS_IRQ_ENTRY)
      else $error("Interrupt entry not forced");
   AST_BKPT_STOP: assert property (
      (q_q.st == ifs_pkg::S_CHECK && bpHit && !wrCtrl) |=>
      (q_q.stop2 && q_q.st == ifs_pkg::S_STOP))
      else $error("Breakpoint did not stop");
   AST_CHAIN: assert property (
      (q_q.st == ifs_pkg::S_LOAD && q_q.chain[`IFS_T1] && !wrCtrl) |=>
      q_q.chain[`IFS_T2] ##1 q_q.chain[`IFS_T3] ##1
      (q_q.chain[`IFS_T4] && (q_q.halfMode || q_q.u == q_q.hold)))
      else $error("Control delay chain broken");
   AST_CLR_FLAG: assert property (
      (q_q.st == ifs_pkg::S_LOAD && q_q.chain[`IFS_T1] && !wrCtrl) |=>
      q_q.clrFlag ##1 q_q.clrFlag ##1 !q_q.clrFlag)
      else $error("Clear flag timing wrong");
   AST_RANK_COPY: assert property (
      (q_q.phase && !wrCtrl) |=> q_q.p2 == $past(q_q.p1))
      else $error("Second rank not reloaded");
   AST_WAIT_HOLD: assert property (
      (q_q.st == ifs_pkg::S_WAIT && !memResume && !wrCtrl) |=>
      q_q.st == ifs_pkg::S_WAIT)
      else $error("Left wait without resume");
   AST_FAULT: assert property (
      (q_q.st == ifs_pkg::S_CHECK && illegal && !wrCtrl) |=>
      (q_q.fault && q_q.stop2 && !q_q.seqStart))
      else $error("Illegal code not stopped");
   AST_MEM_ADDR: assert property (
      q_q.mem.req |-> (q_q.mem.addr == q_q.p2 && q_q.waitStor))
      else $error("Storage started off P");
   COV_BKPT: cover property (q_q.st == ifs_pkg::S_CHECK && bpHit);
   COV_HALF: cover property (q_q.st == ifs_pkg::S_LOAD && q_q.halfMode);
   COV_SELSTOP: cover property (q_q.st == ifs_pkg::S_DISP
      && fCode == `IFS_F_SELSTOP && q_q.selSw);
   COV_IRQ: cover property (q_q.st == ifs_pkg::S_EXEC && exitReq
      && q_q.irqPend);
endmodule

// File: tb/ifs_storage_model.sv
// Interleaved storage model answering fetch requests
`timescale 1ns/1ps
`include "ifs_defines.svh"
module ifs_storage_model (
   input  wire ifs_pkg::ifs_mem_req_t        memOut,
   input  wire logic                         clock,
   output logic                              memResume,
   output logic      [`IFS_WORD_W-1:0]       memData
);
   logic [`IFS_WORD_W-1:0] mem [0:31];
   logic [`IFS_WORD_W-1:0] lastQ;
   int                     lat;
   initial begin
      memResume = 1'b0;
      memData = '0;
      lastQ = '0;
      lat = 1;
      forever begin
         @(posedge clock);
         memResume <= 1'b0;
         // Released bus shows no stale word
         memData <= ~lastQ;
         // One reference at a time per unit
         if (memOut.req === 1'b1) begin
            repeat (lat) @(posedge clock);
            lastQ = mem[memOut.addr[4:0]];
            memResume <= 1'b1;
            memData <= lastQ;
            // Alternate prompt and slow answers
            lat = (lat == 1) ? 5 : 1;
         end
      end
   end
endmodule

// File: tb/test_instruction_fetch_sequencer.sv
// Self-checking bench for the instruction fetch sequencer
`timescale 1ns/1ps
`include "ifs_defines.svh"
module test_instruction_fetch_sequencer;
   logic                  clock, rst_n, psel, penable, pwrite, pready;
   logic                  pslverr, memResume, seqStart, stopFlag;
   logic                  exitReq, exitJump, irqReq;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, rd;
   logic [47:0]           memData;
   logic [6:0]            seqSel;
   logic [23:0]           instrUpper;
   logic [14:0]           progAddr, jumpAddr;
   ifs_pkg::ifs_mem_req_t memOut;
   int                    n_mismatch = 0;
   int                    checked = 0;
   ifs_fetch_sequencer uut (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .memOut(memOut),
      .memResume(memResume), .memData(memData), .seqStart(seqStart),
      .seqSel(seqSel), .instrUpper(instrUpper), .progAddr(progAddr),
      .stopFlag(stopFlag), .exitReq(exitReq), .exitJump(exitJump),
      .jumpAddr(jumpAddr), .irqReq(irqReq));
   ifs_storage_model stor (.memOut(memOut), .clock(clock),
      .memResume(memResume), .memData(memData));
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e,
                      input logic [47:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      chk("pready", 1, pready);
      chk("pslverr", (a > 8'h1C), pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   // Slow storage plus chain: up to a few dozen cycles per wait
   task automatic wait_seq(input logic [6:0] s, input logic [23:0] u);
      int n = 0;
      while (seqStart !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk("seqStart", 1, seqStart);
      chk("seqSel", s, seqSel);
      chk("instrUpper", u, instrUpper);
   endtask
   task automatic wait_req(input logic [14:0] a);
      int n = 0;
      while (memOut.req !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk("memOut.req", 1, memOut.req);
      chk("memOut.addr", a, memOut.addr);
   endtask
   task automatic wait_stop();
      int n = 0;
      while (stopFlag !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      chk("stopFlag", 1, stopFlag);
   endtask
   task automatic do_exit(input logic j, input logic [14:0] a);
      exitReq <= 1'b1;
      exitJump <= j;
      jumpAddr <= a;
      @(posedge clock);
      exitReq <= 1'b0;
      @(posedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      finish_test();
   end
   initial begin
      {rst_n, psel, penable, pwrite, exitReq, exitJump, irqReq} = '0;
      paddr = '0;
      pwdata = '0;
      jumpAddr = '0;
      for (int i = 0; i < 32; i++)
         stor.mem[i] = {6'h01, 18'h0, 6'h01, 18'h0};
      stor.mem[16] = {6'h0C, 18'h00123, 6'h01, 18'h00045};
      stor.mem[17] = {6'h12, 18'h0, 6'h12, 18'h20000};
      stor.mem[5] = {6'h16, 18'h0, 6'h34, 18'h0};
      stor.mem[6] = {6'h3C, 18'h0, 6'h00, 18'h0};
      stor.mem[8] = {6'h01, 18'h0, 6'h0A, 18'h0};
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk("progAddr", 0, progAddr);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped read", 0, rd);
      apb(1'b1, `IFS_A_BKPT, 32'h0000_8008);
      apb(1'b0, `IFS_A_BKPT, 32'h0);
      chk("bkpt", 32'h0000_8008, rd);
      apb(1'b1, `IFS_A_PLOAD, 32'h0000_0010);
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_req(15'h0010);
      wait_seq(`IFS_SEQ_RO, {6'h0C, 18'h00123});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h00045});
      do_exit(1'b0, 15'h0);
      wait_req(15'h0011);
      wait_seq(`IFS_SEQ_NJ, {6'h12, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_WO, {6'h12, 18'h20000});
      do_exit(1'b1, 15'h0005);
      wait_req(15'h0005);
      wait_seq(`IFS_SEQ_IT, {6'h16, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_ST, {6'h34, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_EXF, {6'h3C, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_stop();
      apb(1'b0, `IFS_A_STATUS, 32'h0);
      chk("status", 32'h8018_0006, rd);
      $display("test fetch and dispatch done");
      apb(1'b1, `IFS_A_FCODE, 32'h0000_000A);
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_seq(`IFS_SEQ_RO, {6'h0A, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_req(15'h0007);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_req(15'h0008);
      wait_stop();
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_stop();
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_seq(`IFS_SEQ_RO, {6'h0A, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_req(15'h0009);
      chk("stopFlag", 0, stopFlag);
      $display("test stops and restarts done");
      apb(1'b1, `IFS_A_CTRL, 32'h4);
      chk("progAddr", 0, progAddr);
      chk("stopFlag", 0, stopFlag);
      apb(1'b1, `IFS_A_PLOAD, 32'h0000_7FFF);
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_req(15'h7FFF);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      apb(1'b1, `IFS_A_CTRL, 32'h2);
      do_exit(1'b0, 15'h0);
      wait_req(15'h0000);
      wait_stop();
      apb(1'b1, `IFS_A_CTRL, 32'h2);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_stop();
      irqReq <= 1'b1;
      apb(1'b1, `IFS_A_CTRL, 32'h1);
      wait_seq(`IFS_SEQ_ZA, {6'h01, 18'h0});
      do_exit(1'b0, 15'h0);
      wait_req(`IFS_IRQ_ENTRY);
      $display("test wrap and step done");
      finish_test();
   end
endmodule
